//--- inc/dmr_pkg.sv
`default_nettype none
package dmr_pkg;
	// Mode register select from bank bits {BA1,BA0}
	localparam logic [1:0] MRS_SEL_FIRST = 2'h0;
	localparam logic [1:0] MRS_SEL_EXT1 = 2'h1;
	localparam logic [1:0] MRS_SEL_EXT2 = 2'h2;
	// First mode register fields
	localparam int BIT_BL_LO = 0;
	localparam int BIT_CL_LSB = 2;
	localparam int BIT_CL_LO = 4;
	localparam int BIT_TEST = 7;
	localparam int BIT_DLL_RST = 8;
	localparam int BIT_WR_LO = 9;
	localparam int BIT_PD_FAST = 12;
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_FIXED_BC4 = 2'h2;
	// Extended mode register one fields
	localparam int BIT_DLL_DIS = 0;
	localparam int BIT_DIC0 = 1;
	localparam int BIT_RTT0 = 2;
	localparam int BIT_AL_LO = 3;
	localparam int BIT_DIC1 = 5;
	localparam int BIT_RTT1 = 6;
	localparam int BIT_WLVL = 7;
	localparam int BIT_RTT2 = 9;
	localparam int BIT_TERMINATION_STROBE_ENABLE = 11;
	localparam int BIT_QOFF = 12;
	// Second extended register fields used here
	localparam int BIT_CWL_LO = 3;
	localparam int BIT_RTTWR_LO = 9;
	// Codes and figures
	localparam logic [1:0] AL_ZERO = 2'h0;
	localparam logic [1:0] AL_CL_M1 = 2'h1;
	localparam logic [1:0] AL_CL_M2 = 2'h2;
	localparam logic [4:0] CL_BASE_LO = 5'h04;
	localparam logic [4:0] CL_BASE_HI = 5'h0C;
	localparam logic [4:0] CWL_BASE = 5'h05;
	localparam logic [3:0] BC4_PULLIN = 4'h2;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [4:0] RZQ_OFF = 5'h00;

	// Command bundle sampled from the pins
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic cke;
		logic [2:0] ba;
		logic [15:0] addr;
	} dmr_cmd_t;

	// Power state, Gray along active -> power-down -> self-refresh
	typedef enum logic [1:0] {
		PS_ACTIVE = 2'b00,
		PS_PDOWN = 2'b01,
		PS_SREF = 2'b11
	} dmr_pstate_t;
endpackage
`default_nettype wire

//--- hw/dmr_ctrl.sv
// Operation
// - Test bit one gives unspecified test state
// - DLL reset bit clears itself after launch
// - Write recovery plus precharge sets delay
// - Fixed chop four pulls writes two clocks
// - On-the-fly chop keeps eight-beat write timing
// - Power-down bit selects frozen or running DLL
// - Register write: all strobes low, top bank bit low
// - Termination strobe enable, eight-bit part only
// - Additive latency: zero, CL-1, CL-2
// - Hold read/write for additive latency internally
// - Output-off bit disconnects data and strobes
// - Nominal termination decode, 11x reserved
// - Drive impedance decode RZQ/6 or RZQ/7
// - DLL off in self-refresh, back on exit
// - Dynamic write termination works without nominal
// - Bank bits select target mode register
`timescale 1ns/100ps
`default_nettype none
module dmr_ctrl
	import dmr_pkg::*;
#(
	parameter bit X16_PART = 1'b0,
	parameter logic [4:0] PRECHARGE_CYCLES = 5'h0B
) (
	input wire logic clk, // 25 MHz clock
	input wire logic reset_n, // Async device reset
	input wire dmr_cmd_t cmd_pins, // Command, bank and address pins
	output logic test_mode_q, // Unspecified test state
	output logic dll_reset_pulse_q, // One-cycle DLL reset launch
	output logic [4:0] write_recovery_q, // Write recovery cycles, 0 reserved
	output logic [5:0] auto_precharge_write_delay_q, // Recovery plus precharge
	output logic [3:0] write_pullin_q, // Write start pull-in clocks
	output logic pd_dll_fast_q, // DLL kept in precharge power-down
	output logic dll_running_q, // DLL currently running
	output logic [2:0] drive_rzq_div_q, // 6 or 7, 0 reserved
	output logic [4:0] rtt_nom_div_q, // RZQ divisor, 0 off or reserved
	output logic [4:0] additive_latency_q, // Additive latency cycles
	output logic [4:0] read_latency_q, // Additive plus CAS latency
	output logic [4:0] write_latency_q, // Additive plus CAS write latency
	output logic write_level_q, // Write leveling enabled
	output logic termination_strobe_enable_q, // Termination strobe outputs
	output logic dq_drive_allow_q, // Data and strobe drivers connected
	output logic [2:0] rtt_wr_div_q, // Dynamic write termination divisor
	output logic int_read_q, // Internal read after additive latency
	output logic int_write_q // Internal write after additive latency
);
	dmr_cmd_t s1_q, s2_q, s3_q;
	logic [15:0] first_mode_register_q, extended_mode_register_one_q, ext2_q;
	logic hit_q;
	logic [14:0] rd_pipe_q, wr_pipe_q;
	dmr_pstate_t pstate_q;
	logic agree, cmd_mrs, cmd_ref, cmd_rd, cmd_wr, fire;
	logic [4:0] cl, al, wr, cwl;
	logic [2:0] rtt_code;

	// Three-stage pin synchroniser; stages two and three feed logic
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= '1;
			s2_q <= '1;
			s3_q <= '1;
		end else begin
			s1_q <= cmd_pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Command decode once stages two and three agree
	assign agree = (s2_q == s3_q) && !s3_q.cs_n;
	assign cmd_mrs = agree && !s3_q.ras_n && !s3_q.cas_n && !s3_q.we_n;
	assign cmd_ref = agree && !s3_q.ras_n && !s3_q.cas_n && s3_q.we_n;
	assign cmd_rd = agree && s3_q.ras_n && !s3_q.cas_n && s3_q.we_n;
	assign cmd_wr = agree && s3_q.ras_n && !s3_q.cas_n && !s3_q.we_n;
	// A held command is taken once, on its first agreed cycle
	assign fire = agree && !hit_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hit_q <= 1'b0;
		end else begin
			hit_q <= agree;
		end
	end

	// bank select; fields held until rewritten
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			first_mode_register_q <= REG_RESET;
			extended_mode_register_one_q <= REG_RESET;
			ext2_q <= REG_RESET;
		end else if (cmd_mrs && fire && !s3_q.ba[2]) begin
			unique case (s3_q.ba[1:0])
				MRS_SEL_FIRST: begin
					first_mode_register_q <= s3_q.addr & ~(16'h0001 << BIT_DLL_RST);
				end
				MRS_SEL_EXT1: begin
					extended_mode_register_one_q <= s3_q.addr;
				end
				MRS_SEL_EXT2: begin
					ext2_q <= s3_q.addr;
				end
				default: begin
				end
			endcase
		end
	end

	// DLL reset launched as a single pulse
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dll_reset_pulse_q <= 1'b0;
		end else begin
			dll_reset_pulse_q <= cmd_mrs && fire && !s3_q.ba[2]
				&& (s3_q.ba[1:0] == MRS_SEL_FIRST) && s3_q.addr[BIT_DLL_RST];
		end
	end

	// CAS latency from {A6,A5,A4,A2}
	always_comb begin
		cl = 5'h00;
		if (!first_mode_register_q[BIT_CL_LSB]) begin
			if (first_mode_register_q[BIT_CL_LO +: 3] != 3'h0) begin
				cl = CL_BASE_LO + {2'h0, first_mode_register_q[BIT_CL_LO +: 3]};
			end
		end else if (first_mode_register_q[BIT_CL_LO +: 3] < 3'h3) begin
			cl = CL_BASE_HI + {2'h0, first_mode_register_q[BIT_CL_LO +: 3]};
		end
	end

	// additive latency decode, code 11 reserved as zero
	always_comb begin
		unique case (extended_mode_register_one_q[BIT_AL_LO +: 2])
			AL_ZERO: al = 5'h00;
			AL_CL_M1: al = (cl == 5'h00) ? 5'h00 : cl - 5'h01;
			AL_CL_M2: al = (cl == 5'h00) ? 5'h00 : cl - 5'h02;
			default: al = 5'h00;
		endcase
	end

	always_comb begin
		unique case (first_mode_register_q[BIT_WR_LO +: 3])
			3'h0: wr = 5'h00;
			3'h1: wr = 5'h05;
			3'h2: wr = 5'h06;
			3'h3: wr = 5'h07;
			3'h4: wr = 5'h08;
			3'h5: wr = 5'h0A;
			3'h6: wr = 5'h0C;
			default: wr = 5'h0E;
		endcase
	end

	assign cwl = CWL_BASE + {2'h0, ext2_q[BIT_CWL_LO +: 3]};
	assign rtt_code = {extended_mode_register_one_q[BIT_RTT2],
		extended_mode_register_one_q[BIT_RTT1], extended_mode_register_one_q[BIT_RTT0]};

	// Decoded first-register outputs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			test_mode_q <= 1'b0;
			write_recovery_q <= 5'h00;
			auto_precharge_write_delay_q <= 6'h00;
			write_pullin_q <= 4'h0;
			pd_dll_fast_q <= 1'b0;
		end else begin
			// test state flag only, no test behaviour
			test_mode_q <= first_mode_register_q[BIT_TEST];
			write_recovery_q <= wr;
			auto_precharge_write_delay_q <= {1'b0, wr} + {1'b0, PRECHARGE_CYCLES};
			// fixed chop pulls in; on-the-fly does not
			write_pullin_q <= (first_mode_register_q[BIT_BL_LO +: 2] == BL_FIXED_BC4)
				? BC4_PULLIN : 4'h0;
			pd_dll_fast_q <= first_mode_register_q[BIT_PD_FAST];
		end
	end

	// Decoded extended-register outputs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			drive_rzq_div_q <= 3'h6;
			rtt_nom_div_q <= RZQ_OFF;
			additive_latency_q <= 5'h00;
			read_latency_q <= 5'h00;
			write_latency_q <= 5'h00;
			write_level_q <= 1'b0;
			termination_strobe_enable_q <= 1'b0;
			dq_drive_allow_q <= 1'b1;
			rtt_wr_div_q <= 3'h0;
		end else begin
			// drive impedance, reserved reads as zero
			unique case ({extended_mode_register_one_q[BIT_DIC1],
				extended_mode_register_one_q[BIT_DIC0]})
				2'h0: drive_rzq_div_q <= 3'h6;
				2'h1: drive_rzq_div_q <= 3'h7;
				default: drive_rzq_div_q <= 3'h0;
			endcase
			unique case (rtt_code)
				3'h1: rtt_nom_div_q <= 5'h04;
				3'h2: rtt_nom_div_q <= 5'h02;
				3'h3: rtt_nom_div_q <= 5'h06;
				3'h4: rtt_nom_div_q <= 5'h0C;
				3'h5: rtt_nom_div_q <= 5'h08;
				default: rtt_nom_div_q <= RZQ_OFF;
			endcase
			additive_latency_q <= al;
			read_latency_q <= al + cl;
			write_latency_q <= al + cwl;
			write_level_q <= extended_mode_register_one_q[BIT_WLVL];
			// strobe enable forced off on the sixteen-bit part
			termination_strobe_enable_q <= extended_mode_register_one_q[BIT_TERMINATION_STROBE_ENABLE] && !X16_PART;
			dq_drive_allow_q <= !extended_mode_register_one_q[BIT_QOFF];
			unique case (ext2_q[BIT_RTTWR_LO +: 2])
				2'h1: rtt_wr_div_q <= 3'h4;
				2'h2: rtt_wr_div_q <= 3'h2;
				default: rtt_wr_div_q <= 3'h0;
			endcase
		end
	end

	// Power state tracking for the DLL
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pstate_q <= PS_ACTIVE;
		end else begin
			unique case (pstate_q)
				PS_ACTIVE: begin
					if (cmd_ref && fire && !s3_q.cke) begin
						pstate_q <= PS_SREF;
					end else if ((s2_q.cke == s3_q.cke) && !s3_q.cke) begin
						pstate_q <= PS_PDOWN;
					end
				end
				PS_PDOWN: begin
					if ((s2_q.cke == s3_q.cke) && s3_q.cke) begin
						pstate_q <= PS_ACTIVE;
					end
				end
				PS_SREF: begin
					if ((s2_q.cke == s3_q.cke) && s3_q.cke) begin
						pstate_q <= PS_ACTIVE;
					end
				end
				default: pstate_q <= PS_ACTIVE;
			endcase
		end
	end

	// self-refresh stops DLL; slow exit freezes it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dll_running_q <= 1'b0;
		end else begin
			dll_running_q <= !extended_mode_register_one_q[BIT_DLL_DIS]
				&& (pstate_q != PS_SREF)
				&& !((pstate_q == PS_PDOWN) && !first_mode_register_q[BIT_PD_FAST]);
		end
	end

	// commands held in a delay line for the additive latency
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_pipe_q <= 15'h0000;
			wr_pipe_q <= 15'h0000;
			int_read_q <= 1'b0;
			int_write_q <= 1'b0;
		end else begin
			rd_pipe_q <= {rd_pipe_q[13:0], cmd_rd && fire};
			wr_pipe_q <= {wr_pipe_q[13:0], cmd_wr && fire};
			int_read_q <= (al == 5'h00) ? (cmd_rd && fire) : rd_pipe_q[al[3:0] - 4'h1];
			int_write_q <= (al == 5'h00) ? (cmd_wr && fire) : wr_pipe_q[al[3:0] - 4'h1];
		end
	end

	sequence s_mr0_reset_write;
		cmd_mrs && fire && !s3_q.ba[2] && (s3_q.ba[1:0] == MRS_SEL_FIRST)
			&& s3_q.addr[BIT_DLL_RST];
	endsequence

	a_dll_reset_pulse: assert property (@(posedge clk) disable iff (!reset_n)
		s_mr0_reset_write |=> dll_reset_pulse_q ##1 !dll_reset_pulse_q)
		else $error("DLL reset pulse not single cycle");
	a_dll_bit_clear: assert property (@(posedge clk) disable iff (!reset_n)
		!first_mode_register_q[BIT_DLL_RST])
		else $error("DLL reset bit stayed set");
	a_test_follow: assert property (@(posedge clk) disable iff (!reset_n)
		reset_n |=> (test_mode_q == $past(first_mode_register_q[BIT_TEST])))
		else $error("Test flag did not follow");
	a_pullin_bc4: assert property (@(posedge clk) disable iff (!reset_n)
		(first_mode_register_q[BIT_BL_LO +: 2] == BL_FIXED_BC4) |=> (write_pullin_q == 4'h2))
		else $error("Chop four pull-in missing");
	a_pullin_otf: assert property (@(posedge clk) disable iff (!reset_n)
		(first_mode_register_q[BIT_BL_LO +: 2] == 2'h1) |=> (write_pullin_q == 4'h0))
		else $error("On-the-fly chop pulled in");
	// Sampled reset guard: the release edge still shows reset values
	a_auto_precharge_write_delay_sum: assert property (@(posedge clk) disable iff (!reset_n)
		reset_n |=> (auto_precharge_write_delay_q
			== {1'b0, $past(wr)} + {1'b0, PRECHARGE_CYCLES}))
		else $error("Auto-precharge delay wrong");
	a_qoff_drivers: assert property (@(posedge clk) disable iff (!reset_n)
		extended_mode_register_one_q[BIT_QOFF] |=> !dq_drive_allow_q)
		else $error("Drivers left on with output off");
	a_termination_strobe_enable_x16: assert property (@(posedge clk) disable iff (!reset_n)
		(X16_PART || !extended_mode_register_one_q[BIT_TERMINATION_STROBE_ENABLE]) |=> !termination_strobe_enable_q)
		else $error("Strobe enable on sixteen-bit part");
	a_sref_dll_off: assert property (@(posedge clk) disable iff (!reset_n)
		(pstate_q == PS_SREF) |=> !dll_running_q)
		else $error("DLL running in self-refresh");
	a_rtt_reserved: assert property (@(posedge clk) disable iff (!reset_n)
		(rtt_code[2:1] == 2'h3) |=> (rtt_nom_div_q == RZQ_OFF))
		else $error("Reserved termination code decoded");
	a_al_m1: assert property (@(posedge clk) disable iff (!reset_n)
		(extended_mode_register_one_q[BIT_AL_LO +: 2] == AL_CL_M1) && (cl != 5'h00)
		|=> (additive_latency_q == $past(cl) - 5'h01))
		else $error("Additive latency CL-1 wrong");
	a_ext1_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!(cmd_mrs && fire) |=> $stable(extended_mode_register_one_q))
		else $error("Register changed without write");
	a_read_al0: assert property (@(posedge clk) disable iff (!reset_n)
		(cmd_rd && fire && (al == 5'h00)) |=> int_read_q)
		else $error("Read not issued at zero latency");
endmodule // dmr_ctrl
`default_nettype wire

//--- dv/dmr_mc_model.sv
`timescale 1ns/100ps
`default_nettype none
// Controller side: issues a command, holds it three edges, then deselects
module dmr_mc_model
	import dmr_pkg::*;
(
	input wire logic clk, // Device clock
	output var dmr_cmd_t cmd_pins // Pins toward the device
);
	// Idle deselect with clock enable high until the first command
	initial cmd_pins = 24'hF80000;

	// One command; released lines show the inverse so stale values cannot pass
	task automatic send(input logic [3:0] stb, input logic cke, input logic [2:0] ba,
		input logic [15:0] addr);
		logic [15:0] a;
		a = addr;
		if (stb == 4'h0 && ba == 3'h0) a[7] = 1'b0;
		if (stb == 4'h0 && ba == 3'h1) a = a & 16'h1AFF;
		@(posedge clk);
		cmd_pins <= {stb, cke, ba, a};
		// clock enable held for the whole command
		repeat (3) @(posedge clk);
		cmd_pins <= {4'hF, cke, ~ba, ~a};
		repeat (2) @(posedge clk);
	endtask
endmodule // dmr_mc_model
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import dmr_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	dmr_cmd_t cmd_pins;
	logic test_mode_q, dll_reset_pulse_q, pd_dll_fast_q, dll_running_q, write_level_q;
	logic termination_strobe_enable_q, dq_drive_allow_q, int_read_q, int_write_q;
	logic [4:0] write_recovery_q, rtt_nom_div_q, additive_latency_q, read_latency_q;
	logic [4:0] write_latency_q;
	logic [5:0] auto_precharge_write_delay_q;
	logic [3:0] write_pullin_q;
	logic [2:0] drive_rzq_div_q, rtt_wr_div_q;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	int pulses = 0;
	int rd_at = 0;
	int wr_at = 0;
	// Lock wait before reads; plain default, the real figure is not fixed here
	localparam int DLL_LOCK_CYCLES = 512;

	dmr_ctrl dut (.clk, .reset_n, .cmd_pins, .test_mode_q, .dll_reset_pulse_q,
		.write_recovery_q, .auto_precharge_write_delay_q, .write_pullin_q, .pd_dll_fast_q,
		.dll_running_q, .drive_rzq_div_q, .rtt_nom_div_q, .additive_latency_q,
		.read_latency_q, .write_latency_q, .write_level_q, .termination_strobe_enable_q,
		.dq_drive_allow_q, .rtt_wr_div_q, .int_read_q, .int_write_q);
	dmr_mc_model mc (.clk, .cmd_pins);

	// 25 MHz clock
	always #20 clk = ~clk;

	// Cycle count, pulse bookkeeping and hang guard
	always @(posedge clk) begin
		cycles++;
		if (dll_reset_pulse_q === 1'b1) pulses++;
		if (int_read_q === 1'b1) rd_at = cycles;
		if (int_write_q === 1'b1) wr_at = cycles;
		if (cycles == 5000) begin
			failures++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] want);
		tests_run++;
		if (got !== want) begin
			failures++;
			$display("Error at %0t: got %0h expected %0h", $time, got, want);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	function automatic logic [7:0] wr_of(input int i);
		return (i == 0) ? 8'h00 : (i < 5) ? 8'(i + 4) : 8'(2 * i);
	endfunction

	// Every recovery code, both chop modes, both exit modes
	task automatic t_mr0;
		logic [15:0] a;
		int p;
		for (int i = 0; i < 8; i++) begin
			a = 16'h0080;
			a[11:9] = i[2:0];
			a[12] = i[0];
			a[8] = (i == 3);
			a[1:0] = i[1] ? BL_FIXED_BC4 : 2'h1;
			p = pulses;
			mc.send(4'h0, 1'b1, 3'h0, a);
			settle(2);
			chk(write_recovery_q, wr_of(i));
			chk(auto_precharge_write_delay_q, wr_of(i) + 8'h0B);
			chk(write_pullin_q, i[1] ? 8'h02 : 8'h00);
			chk(pd_dll_fast_q, i[0]);
			chk(test_mode_q, 8'h00);
			chk(8'(pulses - p), (i == 3) ? 8'h01 : 8'h00);
		end
	endtask

	// Every termination code with drive, output-off, strobe and leveling bits
	task automatic t_mr1;
		logic [15:0] a;
		logic [7:0] rz [8];
		rz = '{8'h00, 8'h04, 8'h02, 8'h06, 8'h0C, 8'h08, 8'h00, 8'h00};
		for (int i = 0; i < 8; i++) begin
			a = 16'h0000;
			{a[9], a[6], a[2]} = i[2:0];
			{a[5], a[1]} = i[1:0];
			a[11] = i[1];
			a[7] = i[2];
			// odd termination only with outputs off, DLL off only unterminated
			a[12] = i[0] | i[2];
			a[0] = (i == 0);
			mc.send(4'h0, 1'b1, 3'h1, a);
			settle(2);
			chk(rtt_nom_div_q, rz[i]);
			chk(drive_rzq_div_q, i[1] ? 8'h00 : 8'h06 + i[0]);
			chk(dq_drive_allow_q, !(i[0] | i[2]));
			chk(termination_strobe_enable_q, i[1]);
			chk(write_level_q, i[2]);
			chk(dll_running_q, i != 0);
		end
	endtask

	// Additive latency codes and the internal command delay they give
	task automatic t_al;
		logic [7:0] al [4];
		int s;
		int s2;
		al = '{8'h00, 8'h04, 8'h03, 8'h00};
		// DLL reset, recovery five, lock wait
		mc.send(4'h0, 1'b1, 3'h0, 16'h0310);
		mc.send(4'h0, 1'b1, 3'h2, 16'h0210);
		repeat (DLL_LOCK_CYCLES) @(posedge clk);
		for (int j = 0; j < 4; j++) begin
			mc.send(4'h0, 1'b1, 3'h1, 16'(j << 3));
			settle(2);
			chk(additive_latency_q, al[j]);
			chk(read_latency_q, al[j] + 8'h05);
			chk(write_latency_q, al[j] + 8'h07);
			chk(rtt_wr_div_q, 8'h04);
			s = cycles;
			mc.send(4'h5, 1'b1, 3'h0, 16'h0000);
			#1;
			s2 = cycles;
			mc.send(4'h4, 1'b1, 3'h0, 16'h0000);
			settle(6);
			// Six edges of pin sync and decode come before the additive delay
			chk(8'(rd_at - s), al[j] + 8'h06);
			chk(8'(wr_at - s2), al[j] + 8'h06);
		end
	endtask

	// Writes to the fourth register and with the top bank bit set change nothing
	task automatic t_refuse;
		mc.send(4'h0, 1'b1, 3'h3, 16'h1E02);
		mc.send(4'h0, 1'b1, 3'h5, 16'h1E02);
		settle(2);
		chk(drive_rzq_div_q, 8'h06);
		chk(dq_drive_allow_q, 8'h01);
		chk(write_recovery_q, 8'h05);
		chk(write_latency_q, 8'h07);
	endtask

	// Self-refresh stops the DLL, exit restarts it
	task automatic t_sref;
		mc.send(4'h1, 1'b0, 3'h0, 16'h0000);
		settle(1);
		chk(dll_running_q, 8'h00);
		mc.send(4'hF, 1'b1, 3'h0, 16'h0000);
		settle(2);
		chk(dll_running_q, 8'h01);
		mc.send(4'hF, 1'b0, 3'h0, 16'h0000);
		settle(1);
		chk(dll_running_q, 8'h00);
		mc.send(4'hF, 1'b1, 3'h0, 16'h0000);
		mc.send(4'h0, 1'b1, 3'h0, 16'h1210);
		mc.send(4'hF, 1'b0, 3'h0, 16'h0000);
		settle(1);
		chk(dll_running_q, 8'h01);
		mc.send(4'hF, 1'b1, 3'h0, 16'h0000);
	endtask

	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Reset values, then each scenario in turn
	initial begin
		repeat (2) @(posedge clk);
		#1;
		chk(drive_rzq_div_q, 8'h06);
		chk(dq_drive_allow_q, 8'h01);
		chk(rtt_nom_div_q, 8'h00);
		@(posedge clk);
		reset_n <= 1'b1;
		t_mr0();
		t_mr1();
		t_al();
		t_refuse();
		t_sref();
		tally_and_finish();
	end
endmodule // tb
`default_nettype wire
